// ---- logic/adc_cfg_regs.vh ----
`ifndef ADC_CFG_REGS_VH
`define ADC_CFG_REGS_VH

// Register byte addresses on the register access port.
`define ADDR_MODE_CTRL 8'h04
`define ADDR_FUNC_SEL 8'h05
`define ADDR_DIR_SEL 8'h07
`define ADDR_DRV_TYPE 8'h09
`define ADDR_OUT_LEVEL 8'h0b
`define ADDR_PIN_LEVEL 8'h0d

// Reset values.
`define RST_MODE_CTRL 8'h00
`define RST_FUNC_SEL 8'h00
`define RST_DIR_SEL 8'h00
`define RST_DRV_TYPE 8'h00
`define RST_OUT_LEVEL 8'h00

// Field positions of the mode control register.
`define ERR_CONT_BIT 7
`define TRIG_MODE_HI 6
`define TRIG_MODE_LO 5
`define OSC_CHOICE_BIT 4
`define CLK_DIV_HI 3
`define CLK_DIV_LO 0

// Trigger mode encodings.
`define TRIG_MANUAL 2'h0
`define TRIG_AUTO 2'h1
`define TRIG_FAST_CMP 2'h2

`endif

// ---- logic/pad_drive_ctrl.v ----
`timescale 1ns/1ps
`default_nettype none

module pad_drive_ctrl
(
  input wire clk,
  input wire arst_n,
  input wire [7:0] gpio_en,
  input wire [7:0] dir_sel,
  input wire [7:0] drv_type,
  input wire [7:0] out_level,
  output reg [7:0] pad_out,
  output reg [7:0] pad_oe
);

  // ==========================================================
  // Per-channel output stage
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_pad
      wire drive_en;
      assign drive_en = gpio_en[i] & dir_sel[i];
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          pad_out[i] <= 1'b0;
          pad_oe[i] <= 1'b0;
        end
        else if (!drive_en)
        begin
          pad_out[i] <= 1'b0;
          pad_oe[i] <= 1'b0;
        end
        else if (drv_type[i])
        begin
          // Push-pull drives both levels.
          pad_out[i] <= out_level[i];
          pad_oe[i] <= 1'b1;
        end
        else
        begin
          // Open-drain only pulls low; a high level relies on an external pull-up.
          pad_out[i] <= 1'b0;
          pad_oe[i] <= ~out_level[i];
        end
      end
    end
  endgenerate

endmodule // pad_drive_ctrl

`default_nettype wire

// ---- logic/adc_mode_pin_config.v ----
// Summary of operation
// - The error-continuation bit takes effect only in autonomous or fast comparison mode.
// - With that bit clear, a checksum error leaves sequencing and pin functions untouched.
// - With that bit set, a checksum error forces all channels analog and halts sequencing.
// - Once the checksum error flag clears, sequencing resumes and pin functions return.
// - The trigger mode field selects host-started, autonomous or fast comparison operation.
// - The oscillator choice bit selects the high-speed (0) or low-power (1) oscillator.
// - The four-bit divider field sets the sampling speed from the chosen oscillator.
// - Each function-select bit makes its channel analog (0) or general-purpose (1).
// - Each direction bit makes its general-purpose pin an input (0) or output (1).
// - Each driver-type bit makes its output open-drain (0) or push-pull (1).
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_regs.vh"

module adc_mode_pin_config
(
  input wire clk,
  input wire arst_n,
  input wire sw_reset,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire crc_err_flag,
  input wire [7:0] pad_in,
  output wire [7:0] pad_out,
  output wire [7:0] pad_oe,
  output reg manual_mode,
  output reg auto_mode,
  output reg fast_cmp_mode,
  output reg osc_low_power,
  output reg [3:0] clk_div,
  output reg seq_enable,
  output reg [7:0] analog_sel,
  output reg [7:0] gpio_in_sel
);

  // ==========================================================
  // Register storage
  reg [7:0] mode_ctrl_q;
  reg [7:0] func_sel_q;
  reg [7:0] dir_sel_q;
  reg [7:0] drv_type_q;
  reg [7:0] out_level_q;
  reg [7:0] pad_meta_q;
  reg [7:0] pad_sync_q;
  reg [7:0] rdata_d;
  reg [7:0] gpio_en;
  reg [1:0] trig_mode;
  reg self_running;
  reg err_hold;

  // Decode of a register address, shared by the write and read paths.
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_ctrl_q <= `RST_MODE_CTRL;
      func_sel_q <= `RST_FUNC_SEL;
      dir_sel_q <= `RST_DIR_SEL;
      drv_type_q <= `RST_DRV_TYPE;
      out_level_q <= `RST_OUT_LEVEL;
    end
    else if (sw_reset)
    begin
      mode_ctrl_q <= `RST_MODE_CTRL;
      func_sel_q <= `RST_FUNC_SEL;
      dir_sel_q <= `RST_DIR_SEL;
      drv_type_q <= `RST_DRV_TYPE;
      out_level_q <= `RST_OUT_LEVEL;
    end
    else if (reg_wr)
    begin
      if (hit(reg_addr, `ADDR_MODE_CTRL))
        mode_ctrl_q <= reg_wdata;
      if (hit(reg_addr, `ADDR_FUNC_SEL))
        func_sel_q <= reg_wdata;
      if (hit(reg_addr, `ADDR_DIR_SEL))
        dir_sel_q <= reg_wdata;
      if (hit(reg_addr, `ADDR_DRV_TYPE))
        drv_type_q <= reg_wdata;
      if (hit(reg_addr, `ADDR_OUT_LEVEL))
        out_level_q <= reg_wdata;
    end
  end

  // ==========================================================
  // Pad input synchroniser
  // Pad levels are asynchronous to clk, so two flops precede any reader.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pad_meta_q <= 8'h00;
      pad_sync_q <= 8'h00;
    end
    else
    begin
      pad_meta_q <= pad_in;
      pad_sync_q <= pad_meta_q;
    end
  end

  // ==========================================================
  // Read path
  // Unmapped addresses read as zero; data appears one cycle after reg_rd.
  always @*
  begin
    rdata_d = 8'h00;
    if (hit(reg_addr, `ADDR_MODE_CTRL))
      rdata_d = mode_ctrl_q;
    else if (hit(reg_addr, `ADDR_FUNC_SEL))
      rdata_d = func_sel_q;
    else if (hit(reg_addr, `ADDR_DIR_SEL))
      rdata_d = dir_sel_q;
    else if (hit(reg_addr, `ADDR_DRV_TYPE))
      rdata_d = drv_type_q;
    else if (hit(reg_addr, `ADDR_OUT_LEVEL))
      rdata_d = out_level_q;
    else if (hit(reg_addr, `ADDR_PIN_LEVEL))
      rdata_d = pad_sync_q;
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_d;
  end

  // ==========================================================
  // Mode decode and checksum-error reaction
  // The hold follows the error flag as a level, so clearing the flag releases
  // sequencing and pins in the very next cycle without any extra handshake.
  always @*
  begin
    trig_mode = mode_ctrl_q[`TRIG_MODE_HI:`TRIG_MODE_LO];
    self_running = (trig_mode == `TRIG_AUTO) || (trig_mode == `TRIG_FAST_CMP);
    err_hold = self_running && mode_ctrl_q[`ERR_CONT_BIT] && crc_err_flag;
    gpio_en = err_hold ? 8'h00 : func_sel_q;
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      manual_mode <= 1'b1;
      auto_mode <= 1'b0;
      fast_cmp_mode <= 1'b0;
      osc_low_power <= 1'b0;
      clk_div <= 4'h0;
      seq_enable <= 1'b0;
      analog_sel <= 8'hff;
      gpio_in_sel <= 8'h00;
    end
    else
    begin
      manual_mode <= (trig_mode == `TRIG_MANUAL);
      auto_mode <= (trig_mode == `TRIG_AUTO);
      fast_cmp_mode <= (trig_mode == `TRIG_FAST_CMP);
      osc_low_power <= mode_ctrl_q[`OSC_CHOICE_BIT];
      clk_div <= mode_ctrl_q[`CLK_DIV_HI:`CLK_DIV_LO];
      seq_enable <= self_running && !err_hold;
      analog_sel <= ~gpio_en;
      gpio_in_sel <= gpio_en & ~dir_sel_q;
    end
  end

  // ==========================================================
  // Output drivers
  pad_drive_ctrl u_pad_drive_ctrl
  (
    .clk(clk),
    .arst_n(arst_n),
    .gpio_en(gpio_en),
    .dir_sel(dir_sel_q),
    .drv_type(drv_type_q),
    .out_level(out_level_q),
    .pad_out(pad_out),
    .pad_oe(pad_oe)
  );

endmodule // adc_mode_pin_config

`default_nettype wire

// ---- test/adc_cfg_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Mode and pin relations watched at the block boundary.
module adc_cfg_chk
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sw_reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic crc_err_flag,
  input wire logic [7:0] pad_oe,
  input wire logic manual_mode,
  input wire logic auto_mode,
  input wire logic fast_cmp_mode,
  input wire logic osc_low_power,
  input wire logic [3:0] clk_div,
  input wire logic seq_enable,
  input wire logic [7:0] analog_sel,
  input wire logic [7:0] gpio_in_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic run_mode = auto_mode | fast_cmp_mode;
  a_one_mode: assert property ($onehot0({manual_mode, auto_mode, fast_cmp_mode}))
    else $error("several trigger modes at once");
  a_seq_in_mode: assert property (seq_enable |-> run_mode)
    else $error("sequencing outside a self-running mode");
  a_halt_analog: assert property (run_mode && !seq_enable |-> analog_sel == 8'hff && !pad_oe)
    else $error("halt without all channels analog");
  a_free_run: assert property (run_mode && $past(run_mode) && !$past(crc_err_flag) |-> seq_enable)
    else $error("sequencing stopped without error");
  a_analog_idle: assert property ((analog_sel & (pad_oe | gpio_in_sel)) == 8'h00)
    else $error("analog channel used digitally");
  a_input_idle: assert property ((gpio_in_sel & pad_oe) == 8'h00)
    else $error("digital input is driven");
  a_osc_div: assert property (reg_wr && reg_addr == 8'h04 && !sw_reset |-> ##2
    osc_low_power == $past(reg_wdata[4], 2) && clk_div == $past(reg_wdata[3:0], 2))
    else $error("oscillator or divider not taken");
  a_fast_write: assert property (reg_wr && reg_addr == 8'h04 && reg_wdata[6:5] == 2'h2
    && !sw_reset |-> ##2 fast_cmp_mode)
    else $error("fast comparison mode not taken");
  c_halt: cover property (run_mode && !seq_enable);
  c_fast: cover property (fast_cmp_mode && seq_enable);
  c_drive: cover property (pad_oe != 8'h00);
endmodule // adc_cfg_chk
bind adc_mode_pin_config adc_cfg_chk chk (.*);
`default_nettype wire

// ---- test/pad_board.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Board around the pins: pull-ups and a peer that may drive.
module pad_board
(
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pad_lvl
);
  // Undriven pins float up; the device wins any contention.
  assign pad_lvl = (pad_oe & pad_out) | (~pad_oe & ((ext_en & ext_val) | ~ext_en));
endmodule // pad_board
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Random configurations with error and reset corners.
module tb_top;
  logic clk = 1'b0, arst_n = 1'b0, sw_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic crc_err_flag = 1'b0, manual_mode, auto_mode, fast_cmp_mode, osc_low_power, seq_enable;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ext_val = 8'h00, ext_en = 8'h00;
  logic [7:0] reg_rdata, pad_in, pad_out, pad_oe, analog_sel, gpio_in_sel, f, d, v, l, m;
  logic [3:0] clk_div;
  logic h;
  int fail_count = 0, num_checks = 0, s;
  logic [7:0] rw_addrs [5] = '{8'h04, 8'h05, 8'h07, 8'h09, 8'h0b};
  adc_mode_pin_config dut (.*);
  pad_board env (.pad_lvl(pad_in), .*);
  initial forever #12.5 clk = ~clk;
  function automatic logic [7:0] oe_of(input logic [7:0] f, d, v, l);
    return f & d & (v | ~l);
  endfunction
  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, dv};
    @(negedge clk) reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk) reg_rd = 1'b0;
    chk(reg_rdata, exp, "reg_rdata");
  endtask
  task automatic pins();
    {f, d, v, l} = $urandom;
    {ext_val, ext_en} = 16'($urandom);
    wr(8'h05, f);
    wr(8'h07, d);
    wr(8'h09, v);
    wr(8'h0b, l);
    @(negedge clk);
    chk(analog_sel, ~f, "analog_sel");
    chk(gpio_in_sel, f & ~d, "gpio_in_sel");
    chk(pad_oe, oe_of(f, d, v, l), "pad_oe");
    chk(pad_out, f & d & v & l, "pad_out");
    repeat (2) @(negedge clk);
    rd(8'h0d, (pad_oe & pad_out) | (~pad_oe & ((ext_en & ext_val) | ~ext_en)));
  endtask
  initial
  begin
    s = $urandom(67625);
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    foreach (rw_addrs[i])
      rd(rw_addrs[i], 8'h00);
    rd(8'h01, 8'h00);
    repeat (12)
    begin
      pins();
      m = $urandom;
      for (int k = 0; k < 4; k++)
      begin
        wr(8'h04, {1'b0, k[1:0], m[4:0]});
        @(negedge clk);
        chk({manual_mode, auto_mode, fast_cmp_mode, osc_low_power, clk_div},
            {k == 0, k == 1, k == 2, m[4:0]}, "mode");
        rd(8'h04, {1'b0, k[1:0], m[4:0]});
      end
      for (int k = 0; k < 6; k++)
      begin
        h = k[0] && k > 1;
        wr(8'h04, {k[0], k[2:1], m[4:0]});
        crc_err_flag = 1'b1;
        repeat (2) @(negedge clk);
        chk(analog_sel, h ? 8'hff : ~f, "held analog_sel");
        chk(pad_oe, h ? 8'h00 : oe_of(f, d, v, l), "held pad_oe");
        chk(seq_enable, k > 1 && !h, "held seq_enable");
        crc_err_flag = 1'b0;
        repeat (2) @(negedge clk);
        chk(analog_sel, ~f, "freed analog_sel");
        chk(seq_enable, k > 1, "freed seq_enable");
        chk(pad_oe, oe_of(f, d, v, l), "freed pad_oe");
      end
    end
    sw_reset = 1'b1;
    @(negedge clk) sw_reset = 1'b0;
    rd(8'h05, 8'h00);
    chk(analog_sel, 8'hff, "soft reset analog_sel");
    wr(8'h04, 8'h25);
    @(negedge clk) arst_n = 1'b0;
    @(negedge clk) arst_n = 1'b1;
    chk({manual_mode, auto_mode, seq_enable, analog_sel[4:0]}, 8'h9f, "reset outputs");
    rd(8'h04, 8'h00);
    stop_test();
  end
  initial
  begin
    #500000;
    fail_count++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
